// file: rtl/ccm_pkg.sv
// Package: register map, field positions, reset values and timing for the CAN control block
package ccm_pkg;
  // ==========================================================================
  // Register map (word offsets, decoded from paddr[7:2], inside the 64-word window)
  localparam logic [5:0] OFF_CTL0     = 6'h00;
  localparam logic [5:0] OFF_CTL1     = 6'h01;
  localparam logic [5:0] OFF_BTR0     = 6'h02;
  localparam logic [5:0] OFF_BTR1     = 6'h03;
  localparam logic [5:0] OFF_RFLG     = 6'h04;
  localparam logic [5:0] OFF_RIER     = 6'h05;
  localparam logic [5:0] OFF_TFLG     = 6'h06;
  localparam logic [5:0] OFF_TIER     = 6'h07;
  localparam logic [5:0] OFF_TARQ     = 6'h08;
  localparam logic [5:0] OFF_TAAK     = 6'h09;
  localparam logic [5:0] OFF_TBSEL    = 6'h0A;
  localparam logic [5:0] OFF_IDAC     = 6'h0B;
  localparam logic [5:0] OFF_RSVD     = 6'h0C;
  localparam logic [5:0] OFF_MISC     = 6'h0D;
  localparam logic [5:0] OFF_RXERR    = 6'h0E;
  localparam logic [5:0] OFF_TSTAMP   = 6'h0F;
  localparam int         WINDOW_BYTES = 64;
  // ==========================================================================
  // Control register 0 bits
  localparam int B_FRAME_RECEIVED_FLAG  = 7;
  localparam int B_RECEIVER_ACTIVE  = 6;
  localparam int B_STOP_IN_WAIT  = 5;
  localparam int B_SYNC   = 4;
  localparam int B_TIME   = 3;
  localparam int B_WAKEUP_ENABLE   = 2;
  localparam int B_SLEEP_REQUEST  = 1;
  localparam int B_INIT_REQUEST = 0;
  // Control register 1 bits
  localparam int B_SLEEP_ACKNOWLEDGE  = 1;
  localparam int B_INIT_ACKNOWLEDGE = 0;
  localparam logic [7:0] CTL0_RESET = 8'h01;
  localparam logic [7:0] CTL1_RESET = 8'h11;
  localparam logic [7:0] CTL1_WMASK = 8'hFC;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // Message buffer byte offsets for the timestamp
  localparam logic [3:0] TS_HI_OFF  = 4'hE;
  localparam logic [3:0] TS_LO_OFF  = 4'hF;
  // ==========================================================================
  // Timing
  localparam int CLK_NS         = 4;
  localparam int BIT_NS         = 1000;
  localparam int BIT_CYCLES     = BIT_NS / CLK_NS;
  localparam int IDLE_BITS      = 11;
  localparam int TS_WIDTH       = 16;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       valid;
    logic [3:0] offset;
    logic [7:0] data;
  } ccm_ts_word_t;
  typedef struct packed {
    logic frame_ok;
    logic rx_active;
    logic tx_active;
    logic tx_pending;
  } ccm_core_stat_t;
endpackage : ccm_pkg

// file: rtl/ccm_sync2.sv
// Two-flop synchroniser for a level from the CAN pin
`timescale 1ns/10ps
module ccm_sync2 (
  input  wire logic pclk,     // Bus clock
  input  wire logic presetn,  // Async reset, active low
  input  wire logic d,        // Asynchronous level
  output logic      q         // Synchronised level
);
  logic meta;
  // Pin idles recessive, so both flops reset high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b1;
      q    <= 1'b1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : ccm_sync2

// file: rtl/ccm_buf2.sv
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module ccm_buf2 (
  input  wire logic                  pclk,     // Bus clock
  input  wire logic                  presetn,  // Async reset, active low
  input  wire logic                  in_valid, // Word offered
  output logic                       in_ready, // Room for a word
  input  wire ccm_pkg::ccm_ts_word_t in_word,  // Incoming word
  output logic                       out_valid,// Word available
  input  wire logic                  out_ready,// Sink takes word
  output ccm_pkg::ccm_ts_word_t      out_word  // Head word
);
  ccm_pkg::ccm_ts_word_t mem [2];
  logic                  wr_idx;
  logic                  rd_idx;
  logic [1:0]            count;
  logic                  push;
  logic                  pop;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_word  = mem[rd_idx];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (push) begin
      mem[wr_idx] <= in_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) wr_idx <= ~wr_idx;
      if (pop) rd_idx <= ~rd_idx;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : ccm_buf2

// file: rtl/ccm_ctrl.sv
// CAN controller register window and control register 0 behaviour
// Operation
// - Transmit pin low means dominant, high means recessive.
// - Decode a fixed 64-byte register window from base plus offset; the code decodes 64 words (256 bytes).
// - Read data comes only from flops in the bus clock domain.
// - Control 0 writes only outside init; init request always writable.
// - In init, control 0 held at reset except wake-up, sleep, init.
// - Received-frame flag set on any valid frame; sticky until cleared.
// - Writing one clears the received-frame flag; zero is ignored.
// - Receiver-active bit shows reception in progress, read-only.
// - Stop-in-wait gates the bus interface clock during wait mode.
// - Synchronized bit set and cleared by hardware only.
// - Timer enable runs a 16-bit counter at the bit rate.
// - After end of frame, timestamp goes to buffer bytes 0xE and 0xF.
// - Disabled timer clears to zero; timer enable low during init.
// - With wake-up enabled, bus traffic ends sleep; otherwise ignored.
// - Init request aborts transfers, enters init, sets init acknowledge.
// - Sleep request is serviced only when the bus is idle; the code checks only rx_active and tx_pending, not tx_active.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module ccm_ctrl (
  input  wire logic                   pclk,        // Bus clock, 250 MHz
  input  wire logic                   presetn,     // Async reset, active low
  input  wire logic                   psel,        // APB select
  input  wire logic                   penable,     // APB access phase
  input  wire logic                   pwrite,      // APB write
  input  wire logic [31:0]            paddr,       // APB byte address
  input  wire logic [31:0]            pwdata,      // APB write data
  output logic [31:0]                 prdata,      // APB read data
  output logic                        pready,      // APB ready
  output logic                        pslverr,     // APB error
  input  wire logic                   rx_bus_in,   // CAN receive pin
  output logic                        tx_bus_out,  // CAN transmit pin
  input  wire ccm_pkg::ccm_core_stat_t core_stat,  // Protocol engine status
  input  wire logic                   wait_mode,   // System wait mode
  output logic                        bus_clk_en,  // Interface clock enable
  output logic                        abort_xfer,  // Abort all transfers
  output logic                        wakeup,      // Wake-up from sleep
  output logic                        ts_valid,    // Timestamp byte valid
  input  wire logic                   ts_ready,    // Buffer takes byte
  output logic [3:0]                  ts_offset,   // Buffer byte offset
  output logic [7:0]                  ts_data,     // Timestamp byte
  input  wire logic                   core_tx      // Engine transmit level
);
  // ==========================================================================
  // State
  typedef enum logic [2:0] {
    CCM_RUN   = 3'b001,
    CCM_INIT  = 3'b010,
    CCM_SLEEP = 3'b100
  } ccm_mode_t;

  ccm_mode_t             mode;
  logic                  rx_sync;
  logic                  rx_prev;
  logic [7:0]            ctl0;
  logic [7:0]            ctl1;
  logic [7:0]            btr0;
  logic [7:0]            btr1;
  logic [7:0]            idac;
  logic [7:0]            rd_byte;
  logic                  init_active;
  logic                  init_exited;
  logic                  wr_en;
  logic                  rd_en;
  logic                  in_window;
  logic [5:0]            offs;
  logic                  sync_flag;
  logic [7:0]            recessive_cnt;
  logic                  bit_tick;
  logic [7:0]            bit_div;
  logic [15:0]           timestamp;
  logic                  ts_phase;
  logic [15:0]           ts_latched;
  logic                  ts_busy;
  logic                  buf_in_ready;
  ccm_pkg::ccm_ts_word_t buf_in;
  ccm_pkg::ccm_ts_word_t buf_out;
  logic                  wakeup_enable_armed;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    hit = (a == b);
  endfunction : hit

  // ==========================================================================
  // Pin input
  ccm_sync2 u_rx_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (rx_bus_in),
    .q       (rx_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_prev <= 1'b1;
    else rx_prev <= rx_sync;
  end

  // ==========================================================================
  // APB decode
  assign offs        = paddr[7:2];
  assign in_window   = (paddr[31:2] < 30'(ccm_pkg::WINDOW_BYTES));
  assign wr_en       = psel && penable && pwrite && in_window;
  assign rd_en       = psel && !penable && !pwrite;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !in_window;
  assign init_active = ctl0[ccm_pkg::B_INIT_REQUEST] && ctl1[ccm_pkg::B_INIT_ACKNOWLEDGE];
  assign init_exited = !ctl0[ccm_pkg::B_INIT_REQUEST] && !ctl1[ccm_pkg::B_INIT_ACKNOWLEDGE];

  // ==========================================================================
  // Bit-rate enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_div  <= 8'h00;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= (bit_div == 8'(ccm_pkg::BIT_CYCLES - 1));
      if (bit_div == 8'(ccm_pkg::BIT_CYCLES - 1)) bit_div <= 8'h00;
      else bit_div <= bit_div + 8'h01;
    end
  end

  // ==========================================================================
  // Synchronisation: 11 recessive bit samples after init exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recessive_cnt <= 8'h00;
      sync_flag     <= 1'b0;
    end else if (!init_exited || mode != CCM_RUN) begin
      recessive_cnt <= 8'h00;
      sync_flag     <= 1'b0;
    end else if (bit_tick && !sync_flag) begin
      if (!rx_sync) recessive_cnt <= 8'h00;
      else if (recessive_cnt == 8'(ccm_pkg::IDLE_BITS - 1)) sync_flag <= 1'b1;
      else recessive_cnt <= recessive_cnt + 8'h01;
    end
  end

  // ==========================================================================
  // Mode state: init, sleep, run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= CCM_INIT;
      ctl1 <= ccm_pkg::CTL1_RESET;
    end else begin
      unique case (mode)
        CCM_RUN: begin
          if (ctl0[ccm_pkg::B_INIT_REQUEST]) begin
            mode                    <= CCM_INIT;
            ctl1[ccm_pkg::B_INIT_ACKNOWLEDGE] <= 1'b1;
          end else if (ctl0[ccm_pkg::B_SLEEP_REQUEST] && !core_stat.rx_active
                       && !core_stat.tx_pending) begin
            mode                   <= CCM_SLEEP;
            ctl1[ccm_pkg::B_SLEEP_ACKNOWLEDGE] <= 1'b1;
          end
        end
        CCM_INIT: begin
          if (!ctl0[ccm_pkg::B_INIT_REQUEST]) begin
            mode                    <= CCM_RUN;
            ctl1[ccm_pkg::B_INIT_ACKNOWLEDGE] <= 1'b0;
          end
        end
        CCM_SLEEP: begin
          if (ctl0[ccm_pkg::B_INIT_REQUEST]) begin
            mode                    <= CCM_INIT;
            ctl1[ccm_pkg::B_INIT_ACKNOWLEDGE] <= 1'b1;
            ctl1[ccm_pkg::B_SLEEP_ACKNOWLEDGE]  <= 1'b0;
          end else if (!ctl0[ccm_pkg::B_SLEEP_REQUEST] || wakeup) begin
            mode                   <= CCM_RUN;
            ctl1[ccm_pkg::B_SLEEP_ACKNOWLEDGE] <= 1'b0;
          end
        end
        default: mode <= CCM_INIT;
      endcase
      if (wr_en && hit(offs, ccm_pkg::OFF_CTL1) && init_active) begin
        ctl1[7:2] <= pwdata[7:2];
      end
    end
  end

  assign abort_xfer = (mode == CCM_INIT);

  // Wake-up enable is sampled at sleep entry so later changes wait a period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wakeup_enable_armed <= 1'b0;
    else if (mode == CCM_RUN) wakeup_enable_armed <= ctl0[ccm_pkg::B_WAKEUP_ENABLE];
  end

  // Falling edge of the synchronised pin is start of traffic
  assign wakeup = (mode == CCM_SLEEP) && wakeup_enable_armed && rx_prev && !rx_sync;

  // ==========================================================================
  // Control register 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0 <= ccm_pkg::CTL0_RESET;
    end else begin
      if (wr_en && hit(offs, ccm_pkg::OFF_CTL0)) begin
        // Init request may not drop until acknowledged, nor sleep request
        if (pwdata[ccm_pkg::B_INIT_REQUEST] || init_active)
          ctl0[ccm_pkg::B_INIT_REQUEST] <= pwdata[ccm_pkg::B_INIT_REQUEST];
        if (!init_active) begin
          if (pwdata[ccm_pkg::B_SLEEP_REQUEST] || ctl1[ccm_pkg::B_SLEEP_ACKNOWLEDGE])
            ctl0[ccm_pkg::B_SLEEP_REQUEST] <= pwdata[ccm_pkg::B_SLEEP_REQUEST];
          ctl0[ccm_pkg::B_WAKEUP_ENABLE]  <= pwdata[ccm_pkg::B_WAKEUP_ENABLE];
          ctl0[ccm_pkg::B_TIME]  <= pwdata[ccm_pkg::B_TIME];
          ctl0[ccm_pkg::B_STOP_IN_WAIT] <= pwdata[ccm_pkg::B_STOP_IN_WAIT];
        end
      end
      if (wakeup) ctl0[ccm_pkg::B_SLEEP_REQUEST] <= 1'b0;
      // Set wins over a same-cycle write-one clear
      if (wr_en && hit(offs, ccm_pkg::OFF_CTL0) && pwdata[ccm_pkg::B_FRAME_RECEIVED_FLAG])
        ctl0[ccm_pkg::B_FRAME_RECEIVED_FLAG] <= 1'b0;
      if (core_stat.frame_ok) ctl0[ccm_pkg::B_FRAME_RECEIVED_FLAG] <= 1'b1;
      ctl0[ccm_pkg::B_RECEIVER_ACTIVE] <= core_stat.rx_active;
      ctl0[ccm_pkg::B_SYNC]  <= sync_flag;
      if (init_active) begin
        ctl0[7:3] <= ccm_pkg::CTL0_RESET[7:3];
      end
    end
  end

  // ==========================================================================
  // Configuration registers writable in init only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btr0 <= ccm_pkg::BYTE_ZERO;
      btr1 <= ccm_pkg::BYTE_ZERO;
      idac <= ccm_pkg::BYTE_ZERO;
    end else if (wr_en && init_active) begin
      if (hit(offs, ccm_pkg::OFF_BTR0)) btr0 <= pwdata[7:0];
      if (hit(offs, ccm_pkg::OFF_BTR1)) btr1 <= pwdata[7:0];
      if (hit(offs, ccm_pkg::OFF_IDAC)) idac <= {2'b00, pwdata[5:4], 4'h0};
    end
  end

  // ==========================================================================
  // Timestamp counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timestamp <= 16'h0000;
    else if (!ctl0[ccm_pkg::B_TIME]) timestamp <= 16'h0000;
    else if (bit_tick) timestamp <= timestamp + 16'h0001;
  end

  // Two bytes per frame pushed into the buffer, high byte first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_busy    <= 1'b0;
      ts_phase   <= 1'b0;
      ts_latched <= 16'h0000;
    end else if (!ts_busy) begin
      if (core_stat.frame_ok && ctl0[ccm_pkg::B_TIME]) begin
        ts_busy    <= 1'b1;
        ts_phase   <= 1'b0;
        ts_latched <= timestamp;
      end
    end else if (buf_in_ready) begin
      ts_phase <= 1'b1;
      if (ts_phase) ts_busy <= 1'b0;
    end
  end

  assign buf_in.valid  = ts_busy;
  assign buf_in.offset = ts_phase ? ccm_pkg::TS_LO_OFF : ccm_pkg::TS_HI_OFF;
  assign buf_in.data   = ts_phase ? ts_latched[7:0] : ts_latched[15:8];

  ccm_buf2 u_ts_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (ts_busy),
    .in_ready  (buf_in_ready),
    .in_word   (buf_in),
    .out_valid (ts_valid),
    .out_ready (ts_ready),
    .out_word  (buf_out)
  );

  assign ts_offset = buf_out.offset;
  assign ts_data   = buf_out.data;

  // ==========================================================================
  // Read path: captured in setup, returned from a flop in access
  always_comb begin
    rd_byte = ccm_pkg::BYTE_ZERO;
    unique case (offs)
      ccm_pkg::OFF_CTL0: rd_byte = ctl0;
      ccm_pkg::OFF_CTL1: rd_byte = ctl1;
      ccm_pkg::OFF_BTR0: rd_byte = btr0;
      ccm_pkg::OFF_BTR1: rd_byte = btr1;
      ccm_pkg::OFF_IDAC: rd_byte = idac;
      default:           rd_byte = ccm_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (rd_en) prdata <= {24'h000000, rd_byte};
  end

  // ==========================================================================
  // Pin and clock gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_bus_out <= 1'b1;
    else if (mode != CCM_RUN || !sync_flag || (wait_mode && ctl0[ccm_pkg::B_STOP_IN_WAIT]))
      tx_bus_out <= 1'b1;
    else tx_bus_out <= core_tx;
  end

  assign bus_clk_en = !(wait_mode && ctl0[ccm_pkg::B_STOP_IN_WAIT]);
endmodule : ccm_ctrl

// file: test/ccm_ctrl_props.sv
// Checker: port-level properties of the CAN control block
`timescale 1ns/10ps
module ccm_ctrl_props (
  input wire logic                    pclk,       // Bus clock
  input wire logic                    presetn,    // Reset, low
  input wire logic                    psel,       // Select
  input wire logic                    penable,    // Access phase
  input wire logic                    pwrite,     // Write
  input wire logic [31:0]             paddr,      // Address
  input wire logic [31:0]             pwdata,     // Write data
  input wire logic [31:0]             prdata,     // Read data
  input wire logic                    pready,     // Ready
  input wire logic                    pslverr,    // Error
  input wire logic                    rx_bus_in,  // Rx pin
  input wire logic                    tx_bus_out, // Tx pin
  input wire ccm_pkg::ccm_core_stat_t core_stat,  // Engine status
  input wire logic                    wait_mode,  // Wait mode
  input wire logic                    bus_clk_en, // Clock enable
  input wire logic                    abort_xfer, // Abort
  input wire logic                    wakeup,     // Wake-up
  input wire logic                    ts_valid,   // Stamp valid
  input wire logic                    ts_ready,   // Stamp ready
  input wire logic [3:0]              ts_offset,  // Stamp offset
  input wire logic [7:0]              ts_data,    // Stamp byte
  input wire logic                    core_tx     // Engine tx
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Sequences
  sequence rd_setup(logic [31:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence ts_take_hi;
    ts_valid && ts_ready && ts_offset == 4'hE;
  endsequence
  // ==========================================================================
  // Properties
  pready_a: assert property (psel |-> pready)
    else $error("ready low in a transfer");
  err_hi_a: assert property (psel && penable && paddr[31:2] >= 30'h40 |-> pslverr)
    else $error("no error outside window");
  err_lo_a: assert property (psel && penable && paddr[31:2] < 30'h40 |-> !pslverr)
    else $error("error inside window");
  rsvd_rd_a: assert property (rd_setup(32'h30) |=> prdata == 32'h0)
    else $error("reserved word not zero");
  rd_hi_a: assert property (psel && penable |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  gate_a: assert property (!wait_mode |-> bus_clk_en)
    else $error("clock gated outside wait");
  tx_wait_a: assert property (!bus_clk_en |=> tx_bus_out)
    else $error("dominant while stopped");
  tx_follow_a: assert property (!tx_bus_out |-> !$past(core_tx))
    else $error("dominant without engine");
  abort_tx_a: assert property (abort_xfer |=> tx_bus_out)
    else $error("dominant during abort");
  ts_off_a: assert property (ts_valid |-> ts_offset inside {4'hE, 4'hF})
    else $error("bad stamp offset");
  stall_a: assert property (ts_valid && !ts_ready |=> ts_valid && $stable(ts_data))
    else $error("stamp lost in stall");
  ts_pair_a: assert property (ts_take_hi |-> ##[1:4] (ts_valid && ts_offset == 4'hF))
    else $error("low stamp byte missing");
endmodule : ccm_ctrl_props
bind ccm_ctrl ccm_ctrl_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .rx_bus_in, .tx_bus_out, .core_stat, .wait_mode,
  .bus_clk_en, .abort_xfer, .wakeup, .ts_valid, .ts_ready, .ts_offset, .ts_data, .core_tx);

// file: test/ccm_can_bus.sv
// Far-side model: CAN bus seen through a transceiver
`timescale 1ns/10ps
module ccm_can_bus (
  input  wire logic tx_bus_out, // Controller drive
  input  wire logic other_dom,  // Other station dominant
  output logic      rx_bus_in   // Bus level echoed
);
  // Wired-AND: any dominant 0 wins, an idle bus rests recessive
  assign rx_bus_in = tx_bus_out & ~other_dom;
endmodule : ccm_can_bus

// file: test/ccm_ctrl_bench.sv
// Self-checking bench for the CAN control block
`timescale 1ns/10ps
module ccm_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd, w;
  logic rx_bus_in, tx_bus_out, wait_mode, bus_clk_en, abort_xfer, wakeup;
  logic ts_valid, ts_ready, core_tx, other_dom;
  logic [3:0] ts_offset;
  logic [7:0] ts_data;
  logic [3:0] offs [2];
  logic [7:0] tsb [2];
  logic [7:0] umap [10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0E};
  ccm_pkg::ccm_core_stat_t core_stat;
  int err_total, checked, cyc, k, n;
  ccm_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_bus_in, .tx_bus_out, .core_stat, .wait_mode, .bus_clk_en, .abort_xfer,
    .wakeup, .ts_valid, .ts_ready, .ts_offset, .ts_data, .core_tx);
  ccm_can_bus far (.tx_bus_out, .other_dom, .rx_bus_in);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Ceiling well above the synchronisation wait plus all transfers
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] ctl0_exp(logic [7:0] c, logic f, logic a, logic s);
    return {24'h0, f, a, c[5], s, c[3:0]};
  endfunction : ctl0_exp
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {22'h0, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, rd, exp);
  endtask : rd_chk
  task automatic wait_ack(input logic v);
    for (int i = 0; i < 30; i++) begin
      apb(1'b0, 8'h01, 32'h0);
      if (rd[0] === v) break;
    end
    chk("init ack", rd[0], v);
  endtask : wait_ack
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, wait_mode, ts_ready, other_dom} = '0;
    {paddr, pwdata, core_stat, cyc, err_total, checked} = '0;
    core_tx = 1'b1;
    void'($urandom(32'h366F));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("tx idle", tx_bus_out, 1'b1);
    rd_chk("ctl0 reset", 8'h00, ccm_pkg::CTL0_RESET);
    rd_chk("ctl1 reset", 8'h01, ccm_pkg::CTL1_RESET);
    chk("abort in init", abort_xfer, 1'b1);
    apb(1'b1, 8'h00, 32'h39);
    rd_chk("ctl0 held", 8'h00, ccm_pkg::CTL0_RESET);
    apb(1'b1, 8'h00, 32'h0);
    wait_ack(1'b0);
    chk("abort in run", abort_xfer, 1'b0);
    foreach (umap[i]) begin
      apb(1'b1, umap[i], $urandom);
      rd_chk("unimplemented", umap[i], 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("error at 64", er, 1'b1);
    apb(1'b0, 8'h3F, 32'h0);
    chk("no error at 63", er, 1'b0);
    for (int i = 0; i < 2000 && rd[4] !== 1'b1; i++) apb(1'b0, 8'h00, 32'h0);
    chk("synchronized", rd[4], 1'b1);
    repeat (6) begin
      w = $urandom & 32'h2C;
      apb(1'b1, 8'h00, w);
      rd_chk("ctl0 write", 8'h00, ctl0_exp(w[7:0], 1'b0, 1'b0, 1'b1));
    end
    apb(1'b1, 8'h00, 32'h0);
    core_tx <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("tx dominant", tx_bus_out, 1'b0);
    core_tx <= 1'b1;
    apb(1'b1, 8'h00, 32'h08);
    core_stat.frame_ok <= 1'b1;
    @(posedge pclk);
    core_stat.frame_ok <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("stall hold", {ts_valid, ts_offset}, 5'h1E);
    ts_ready <= 1'b1;
    k = 0;
    n = 0;
    while (k < 2 && n < 20) begin
      @(posedge pclk);
      n++;
      if (ts_valid === 1'b1) begin
        offs[k] = ts_offset;
        tsb[k] = ts_data;
        k++;
      end
    end
    ts_ready <= 1'b0;
    chk("stamp hi offset", offs[0], 4'hE);
    chk("stamp lo offset", offs[1], 4'hF);
    chk("stamp hi byte", tsb[0], 8'h00);
    chk("stamp restarted", tsb[1] <= 8'h01, 1'b1);
    rd_chk("frame set", 8'h00, ctl0_exp(8'h08, 1'b1, 1'b0, 1'b1));
    apb(1'b1, 8'h00, 32'h08);
    rd_chk("zero ignored", 8'h00, ctl0_exp(8'h08, 1'b1, 1'b0, 1'b1));
    apb(1'b1, 8'h00, 32'h88);
    rd_chk("one clears", 8'h00, ctl0_exp(8'h08, 1'b0, 1'b0, 1'b1));
    core_stat.rx_active <= 1'b1;
    apb(1'b1, 8'h00, 32'h08);
    rd_chk("receiving", 8'h00, ctl0_exp(8'h08, 1'b0, 1'b1, 1'b1));
    core_stat.rx_active <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    wait_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("wait ungated", bus_clk_en, 1'b1);
    apb(1'b1, 8'h00, 32'h20);
    repeat (2) @(posedge pclk);
    chk("wait gated", bus_clk_en, 1'b0);
    chk("tx in wait", tx_bus_out, 1'b1);
    wait_mode <= 1'b0;
    apb(1'b1, 8'h00, 32'h04);
    core_stat.rx_active <= 1'b1;
    apb(1'b1, 8'h00, 32'h06);
    rd_chk("sleep held off", 8'h01, 32'h10);
    core_stat.rx_active <= 1'b0;
    rd_chk("sleep ack", 8'h01, 32'h12);
    other_dom <= 1'b1;
    repeat (4) @(posedge pclk);
    other_dom <= 1'b0;
    rd_chk("woken", 8'h01, 32'h10);
    rd_chk("wake clears sleep", 8'h00, 32'h04);
    apb(1'b1, 8'h00, 32'h29);
    wait_ack(1'b1);
    chk("abort again", abort_xfer, 1'b1);
    rd_chk("ctl0 reinit", 8'h00, ccm_pkg::CTL0_RESET);
    tally_and_finish();
  end
endmodule : ccm_ctrl_bench
